// *** logic/lcdxf_pkg.sv ***
/*
 * Shared constants for the segment-driver data transfer block: register
 * offsets, field positions, reset values, the interrupt vector and the
 * transfer sequencer states.
 * Assumes byte-wide registers on a 16-bit address port.
 */
package lcdxf_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE = 16'hFF60;
	localparam logic [15:0] ADDR_XFER = 16'hFF61;
	localparam logic [15:0] ADDR_IRQ = 16'hFF68;

	// ----------------------------------------------------------------
	// mode control fields
	// ----------------------------------------------------------------
	localparam int unsigned MODE_WIDTH_BIT = 0;
	localparam int unsigned MODE_GRAY_BIT = 1;
	localparam int unsigned MODE_HALF_BIT = 2;
	localparam int unsigned MODE_DIV_LO = 3;
	localparam int unsigned MODE_INV_BIT = 6;
	localparam int unsigned MODE_BLANK_BIT = 7;
	localparam logic [7:0] MODE_RST = 8'h00;

	// ----------------------------------------------------------------
	// transfer control and status fields
	// ----------------------------------------------------------------
	localparam int unsigned XFER_CONT_BIT = 0;
	localparam int unsigned XFER_TRIG_BIT = 1;
	localparam int unsigned XFER_AUTO_BIT = 2;
	localparam int unsigned XFER_EN_BIT = 3;
	localparam int unsigned XFER_ABUSY_BIT = 4;
	localparam logic XFER_CONT_RST = 1'h1;

	// ----------------------------------------------------------------
	// interrupt control fields and vector
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_FLAG_BIT = 0;
	localparam int unsigned IRQ_MASK_BIT = 1;
	localparam int unsigned IRQ_PRIO_LO = 2;
	localparam logic [1:0] IRQ_PRIO_RST = 2'h0;
	localparam logic [23:0] IRQ_VECTOR = 24'h000024;

	// ----------------------------------------------------------------
	// scan divider: ratio in half steps is select plus this offset
	// ----------------------------------------------------------------
	localparam logic [4:0] RATIO_OFFSET = 5'h02;
	localparam logic [4:0] HALF_STEPS_PER_TICK = 5'h02;

	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_HI, ST_LO} lcdxf_state_t;

endpackage

// *** logic/lcdxf_scan_div.sv ***
/*
 * Scan line divider: emits one line tick per ratio of base oscillator
 * ticks, ratio 1 to 8.5 in half steps.
 * Assumes base_tick_in is a one-cycle pulse per base oscillator period.
 */
`timescale 1ns/10ps
module lcdxf_scan_div (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic run_in,
	// base oscillator tick and ratio select
	input wire logic base_tick_in,
	input wire logic [3:0] ratio_sel_in,
	// line tick
	output logic line_tick_out
);
	logic [4:0] acc_q;
	logic [4:0] acc_d;
	logic tick_d;
	logic tick_q;
	logic [4:0] target;
	logic [4:0] sum;

	// half-step accumulator: adds two per base tick, wraps at ratio*2
	always_comb begin
		target = {1'b0, ratio_sel_in} + lcdxf_pkg::RATIO_OFFSET;
		sum = acc_q + lcdxf_pkg::HALF_STEPS_PER_TICK;
		acc_d = acc_q;
		tick_d = 1'b0;
		if (!run_in) begin
			acc_d = 5'h00;
		end else if (acc_q >= target) begin
			// ratio lowered mid-count: restart rather than tick on every base tick
			acc_d = 5'h00;
		end else if (base_tick_in) begin
			if (sum >= target) begin
				acc_d = sum - target;
				tick_d = 1'b1;
			end else begin
				acc_d = sum;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			acc_q <= 5'h00;
			tick_q <= 1'b0;
		end else if (ce_in) begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign line_tick_out = tick_q;
endmodule // lcdxf_scan_div

// *** logic/lcdxf_top.sv ***
/*
 * Segment-driver data transfer: fetches display memory, shifts it out as
 * 4-bit or 8-bit units, drives frame/line/scan signals and raises the
 * transfer-complete interrupt.
 * Assumes display memory answers a read one cycle after mem_rd_out, and
 * that the scan line period exceeds one line of shifting.
 */
// Decided for this implementation: the strobed register port.
// What this block does
// - shift four or eight bit units by width
// - continuous refresh on write or after reset
// - continuous mode sends image every powered frame
// - both mode bits zero selects one-shot
// - no pending frame: control signals only
// - trigger sends exactly one frame from the next frame start
// - trigger reads busy; busy trigger ignored
// - auto bit alone selects auto-transfer
// - any display write queues one frame
// - auto status reads one while sending
// - demand transfer completion sets interrupt flag
// - mask gates request, not the flag
// - interrupt priority selectable zero to three
// - interrupt uses fixed vector address
// - scan clock divides base by ratio
// - transfer control bit layout and reset
`timescale 1ns/10ps
module lcdxf_top #(
	parameter int unsigned FRAME_LINES = 8,
	parameter int unsigned LINE_BYTES = 4,
	parameter logic [15:0] DISPLAY_BLANK_CTL_BASE = 16'hF000
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// register port
	input wire logic [15:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// base oscillator tick and display memory write notice
	input wire logic base_tick_in,
	input wire logic display_blank_ctl_write_in,
	// display memory read port
	output logic mem_rd_out,
	output logic [15:0] mem_addr_out,
	input wire logic [7:0] mem_data_in,
	// segment driver link
	output logic [7:0] seg_data_out,
	output logic seg_shift_out,
	output logic line_latch_pulse_out,
	output logic scan_start_pulse_out,
	output logic frame_polarity_signal_out,
	// interrupt request
	output logic lcd_irq_req_out,
	output logic [1:0] lcd_irq_priority_out,
	output logic [23:0] lcd_irq_vector_out
);
	localparam int unsigned LW = (FRAME_LINES > 1) ? $clog2(FRAME_LINES) : 1;
	localparam int unsigned BW = (LINE_BYTES > 1) ? $clog2(LINE_BYTES) : 1;
	localparam logic [LW-1:0] LINE_LAST = LW'(FRAME_LINES - 1);
	localparam logic [BW-1:0] BYTE_LAST = BW'(LINE_BYTES - 1);

	typedef struct packed {
		logic [7:0] mode;
		logic cont;
		logic busy1;
		logic auto_on;
		logic en;
		logic irq_flag;
		logic irq_mask;
		logic [1:0] prio;
		logic pend;
		logic xfer;
		logic demand;
		logic [LW-1:0] line;
		logic [BW-1:0] bytecnt;
		logic [15:0] addr;
		lcdxf_pkg::lcdxf_state_t st;
		logic [7:0] byte_buf;
		logic [7:0] rdata;
		logic mem_rd;
		logic [7:0] seg_data;
		logic seg_shift;
		logic latch;
		logic scan;
		logic fr;
		logic irq_req;
		logic [23:0] vec;
	} lcdxf_state_reg_t;

	lcdxf_state_reg_t cs;
	lcdxf_state_reg_t ns;
	logic line_tick;
	logic done_w;
	logic [7:0] pix;

	// ----------------------------------------------------------------
	// scan line divider
	// ----------------------------------------------------------------
	lcdxf_scan_div u_div (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.run_in(cs.en),
		.base_tick_in(base_tick_in),
		.ratio_sel_in(cs.mode[lcdxf_pkg::MODE_DIV_LO +: 3] ==  3'h0 && !cs.mode[lcdxf_pkg::MODE_HALF_BIT]
			? 4'h0 : {cs.mode[lcdxf_pkg::MODE_DIV_LO +: 3], cs.mode[lcdxf_pkg::MODE_HALF_BIT]}),
		.line_tick_out(line_tick)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		ns = cs;
		done_w = 1'b0;
		ns.mem_rd = 1'b0;
		ns.seg_shift = 1'b0;
		ns.latch = 1'b0;
		ns.scan = 1'b0;
		ns.rdata = 8'h00;
		// pixel byte: inverse video, then forced blanking
		pix = cs.mode[lcdxf_pkg::MODE_INV_BIT] ? ~mem_data_in : mem_data_in;
		if (!cs.mode[lcdxf_pkg::MODE_BLANK_BIT]) begin
			pix = 8'h00;
		end
		// byte sequencer: fetch, wait, shift high then low nibble, or the whole byte in eight-bit mode
		unique case (cs.st)
			lcdxf_pkg::ST_IDLE: begin
				ns.st = lcdxf_pkg::ST_IDLE;
			end
			lcdxf_pkg::ST_FETCH: begin
				ns.mem_rd = 1'b1;
				ns.st = lcdxf_pkg::ST_LOAD;
			end
			lcdxf_pkg::ST_LOAD: begin
				ns.st = lcdxf_pkg::ST_HI;
			end
			lcdxf_pkg::ST_HI: begin
				ns.byte_buf = pix;
				ns.seg_shift = 1'b1;
				if (cs.mode[lcdxf_pkg::MODE_WIDTH_BIT]) begin
					ns.seg_data = pix;
				end else begin
					ns.seg_data = {4'h0, pix[7:4]};
					ns.st = lcdxf_pkg::ST_LO;
				end
			end
			lcdxf_pkg::ST_LO: begin
				ns.seg_data = {4'h0, cs.byte_buf[3:0]};
				ns.seg_shift = 1'b1;
			end
		endcase
		// advance after the last unit of a byte
		if ((cs.st == lcdxf_pkg::ST_HI && cs.mode[lcdxf_pkg::MODE_WIDTH_BIT])
			|| cs.st == lcdxf_pkg::ST_LO) begin
			ns.addr = cs.addr + 16'h0001;
			if (cs.bytecnt == BYTE_LAST) begin
				ns.st = lcdxf_pkg::ST_IDLE;
				ns.bytecnt = '0;
				if (cs.line == LINE_LAST && cs.xfer) begin
					ns.xfer = 1'b0;
					done_w = cs.demand;
					if (cs.demand) begin
						ns.busy1 = 1'b0;
					end
				end
			end else begin
				ns.bytecnt = cs.bytecnt + 1'b1;
				ns.st = lcdxf_pkg::ST_FETCH;
			end
		end
		// line tick: latch every line, scan start and polarity per frame
		if (line_tick && cs.en) begin
			ns.latch = 1'b1;
			ns.bytecnt = '0;
			ns.st = cs.xfer ? lcdxf_pkg::ST_FETCH : lcdxf_pkg::ST_IDLE;
			if (cs.line == LINE_LAST) begin
				ns.line = '0;
				ns.scan = 1'b1;
				ns.fr = ~cs.fr;
				ns.addr = DISPLAY_BLANK_CTL_BASE;
				ns.xfer = cs.cont || cs.pend;
				ns.demand = !cs.cont;
				if (!cs.cont) begin
					ns.pend = 1'b0;
				end
				ns.st = (cs.cont || cs.pend) ? lcdxf_pkg::ST_FETCH : lcdxf_pkg::ST_IDLE;
			end else begin
				ns.line = cs.line + 1'b1;
			end
		end
		// power off: stop; an unfinished demand frame is re-queued
		if (!cs.en) begin
			ns.st = lcdxf_pkg::ST_IDLE;
			ns.xfer = 1'b0;
			ns.line = LINE_LAST;
			ns.pend = cs.pend || (cs.xfer && cs.demand);
		end
		// register writes
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				lcdxf_pkg::ADDR_MODE: ns.mode = reg_wdata_in;
				lcdxf_pkg::ADDR_XFER: begin
					ns.cont = reg_wdata_in[lcdxf_pkg::XFER_CONT_BIT];
					ns.auto_on = reg_wdata_in[lcdxf_pkg::XFER_AUTO_BIT];
					ns.en = reg_wdata_in[lcdxf_pkg::XFER_EN_BIT];
					// one-shot only when both mode bits are zero
					if (reg_wdata_in[lcdxf_pkg::XFER_TRIG_BIT] && !cs.busy1
						&& !ns.cont && !ns.auto_on) begin
						ns.busy1 = 1'b1;
						ns.pend = 1'b1;
					end
				end
				lcdxf_pkg::ADDR_IRQ: begin
					if (reg_wdata_in[lcdxf_pkg::IRQ_FLAG_BIT]) begin
						ns.irq_flag = 1'b0;
					end
					ns.irq_mask = reg_wdata_in[lcdxf_pkg::IRQ_MASK_BIT];
					ns.prio = reg_wdata_in[lcdxf_pkg::IRQ_PRIO_LO +: 2];
				end
				default: ns.mode = ns.mode;
			endcase
		end
		// auto mode: any display memory write queues a frame
		if (display_blank_ctl_write_in && cs.auto_on && !cs.cont) begin
			ns.pend = 1'b1;
		end
		// completion sets the flag; set wins over a clear
		if (done_w) begin
			ns.irq_flag = 1'b1;
		end
		ns.irq_req = ns.irq_flag && ns.irq_mask;
		ns.vec = lcdxf_pkg::IRQ_VECTOR;
		// register reads, answered next cycle
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				lcdxf_pkg::ADDR_MODE: ns.rdata = cs.mode;
				lcdxf_pkg::ADDR_XFER: begin
					ns.rdata[lcdxf_pkg::XFER_CONT_BIT] = cs.cont;
					ns.rdata[lcdxf_pkg::XFER_TRIG_BIT] = cs.busy1;
					ns.rdata[lcdxf_pkg::XFER_AUTO_BIT] = cs.auto_on;
					ns.rdata[lcdxf_pkg::XFER_EN_BIT] = cs.en;
					ns.rdata[lcdxf_pkg::XFER_ABUSY_BIT] = cs.xfer && cs.demand && cs.auto_on;
				end
				lcdxf_pkg::ADDR_IRQ: begin
					ns.rdata[lcdxf_pkg::IRQ_FLAG_BIT] = cs.irq_flag;
					ns.rdata[lcdxf_pkg::IRQ_MASK_BIT] = cs.irq_mask;
					ns.rdata[lcdxf_pkg::IRQ_PRIO_LO +: 2] = cs.prio;
				end
				default: ns.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cs <= '0;
			cs.mode <= lcdxf_pkg::MODE_RST;
			cs.cont <= lcdxf_pkg::XFER_CONT_RST;
			cs.prio <= lcdxf_pkg::IRQ_PRIO_RST;
			cs.line <= LINE_LAST;
			cs.addr <= DISPLAY_BLANK_CTL_BASE;
			cs.st <= lcdxf_pkg::ST_IDLE;
			cs.vec <= lcdxf_pkg::IRQ_VECTOR;
		end else if (ce_in) begin
			cs <= ns;
		end
	end

	// outputs straight from the state register
	assign reg_rdata_out = cs.rdata;
	assign mem_rd_out = cs.mem_rd;
	assign mem_addr_out = cs.addr;
	assign seg_data_out = cs.seg_data;
	assign seg_shift_out = cs.seg_shift;
	assign line_latch_pulse_out = cs.latch;
	assign scan_start_pulse_out = cs.scan;
	assign frame_polarity_signal_out = cs.fr;
	assign lcd_irq_req_out = cs.irq_req;
	assign lcd_irq_priority_out = cs.prio;
	assign lcd_irq_vector_out = cs.vec;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in || !ce_in);

	chk_width_four: assert property (
		seg_shift_out && !$past(cs.mode[lcdxf_pkg::MODE_WIDTH_BIT]) |-> seg_data_out[7:4] == 4'h0)
		else $error("upper nibble driven in four-bit mode");
	chk_reset_cont: assert property (
		$past(sys_rst_in) |-> cs.cont && !cs.busy1)
		else $error("continuous refresh not set after reset");
	chk_cont_frame: assert property (
		line_tick && cs.en && cs.cont && cs.line == LINE_LAST |=> cs.xfer ##1 mem_rd_out)
		else $error("continuous frame not started");
	chk_idle_shift: assert property (
		seg_shift_out |-> $past(cs.xfer))
		else $error("data shifted with no frame pending");
	chk_trigger_busy: assert property (
		reg_wr_in && reg_addr_in == lcdxf_pkg::ADDR_XFER && reg_wdata_in == 8'h0A
		&& !cs.busy1 |=> cs.busy1 && cs.pend)
		else $error("trigger did not set busy");
	chk_busy_held: assert property (
		cs.busy1 && !done_w |=> cs.busy1)
		else $error("busy dropped before completion");
	chk_auto_queue: assert property (
		display_blank_ctl_write_in && cs.auto_on && !cs.cont |=> cs.pend || cs.xfer)
		else $error("display write did not queue frame");
	chk_auto_status: assert property (
		reg_rd_in && reg_addr_in == lcdxf_pkg::ADDR_XFER |=>
		reg_rdata_out[lcdxf_pkg::XFER_ABUSY_BIT] == $past(cs.xfer && cs.demand && cs.auto_on))
		else $error("auto status bit wrong");
	chk_flag_set: assert property (
		done_w |=> cs.irq_flag ##1 (lcd_irq_req_out == cs.irq_mask || !cs.irq_flag))
		else $error("flag not set on completion");
	chk_irq_mask: assert property (
		lcd_irq_req_out == (cs.irq_flag && cs.irq_mask))
		else $error("request not gated by mask");
	chk_vector_fixed: assert property (
		lcd_irq_vector_out == 24'h000024)
		else $error("vector changed");

	cov_oneshot_done: cover property (done_w && !cs.auto_on);
	cov_auto_done: cover property (done_w && cs.auto_on);
	cov_cont_frame: cover property (scan_start_pulse_out && cs.cont && cs.xfer);
	cov_eight_bit: cover property (seg_shift_out && cs.mode[lcdxf_pkg::MODE_WIDTH_BIT]);
endmodule // lcdxf_top

// *** verification/lcdxf_mem_model.sv ***
/*
 * display memory model for the transfer block bench.
 * assumes the block pulses rd_in one cycle per byte and samples data a cycle later.
 */
`timescale 1ns/10ps
module lcdxf_mem_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// read port
	input wire logic rd_in,
	input wire logic [15:0] addr_in,
	output logic [7:0] data_out
);
	// byte is a scramble of its address; idle bus flips every cycle
	always @(posedge clk_in) begin
		if (rst_in) begin
			data_out <= 8'h3C;
		end else if (rd_in) begin
			data_out <= addr_in[7:0] ^ 8'hA5;
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule // lcdxf_mem_model

// *** verification/tb.sv ***
/*
 * bench: reset values, refresh, divider, one-shot, auto and interrupt.
 * assumes the memory model answers the block's reads.
 */
`timescale 1ns/10ps
module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, rst, ce, wr, rd, tick, dwr, mrd, sh, lat, scn, fps, req;
	logic [15:0] addr, maddr;
	logic [7:0] wd, rdat, mdat, sd, rv;
	logic [1:0] prio;
	logic [23:0] vec;
	int errors, num_checks, nlat, tcnt, s0;
	logic [7:0] units[$];

	// block and memory
	lcdxf_top DUT (.sys_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .base_tick_in(tick), .display_blank_ctl_write_in(dwr),
		.mem_rd_out(mrd), .mem_addr_out(maddr), .mem_data_in(mdat),
		.seg_data_out(sd), .seg_shift_out(sh), .line_latch_pulse_out(lat),
		.scan_start_pulse_out(scn), .frame_polarity_signal_out(fps),
		.lcd_irq_req_out(req), .lcd_irq_priority_out(prio), .lcd_irq_vector_out(vec));
	lcdxf_mem_model mem (.clk_in(clk), .rst_in(rst), .rd_in(mrd), .addr_in(maddr),
		.data_out(mdat));

	// clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// base tick every 24 clocks; tally units and latches
	always @(posedge clk) begin
		tcnt <= (tcnt == 23) ? 0 : tcnt + 1;
		tick <= (tcnt == 23);
		if (sh === 1'b1) units.push_back(sd);
		if (lat === 1'b1) nlat <= nlat + 1;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkn(string n, int lo, int hi, int g);
		num_checks++;
		if (g < lo || g > hi) begin
			errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask

	task automatic wreg(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask

	task automatic rchk(string n, logic [15:0] a, logic [7:0] e);
		rreg(a, rv);
		chk(n, e, rv);
	endtask

	task automatic hang(string n);
		errors++;
		$display("[FAIL] %s expected event seen timeout", n);
		end_of_test();
	endtask

	task automatic wait_scan();
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if (scn === 1'b1) return;
		end
		hang("scan start");
	endtask

	task automatic poll(logic [7:0] m, logic [7:0] v);
		for (int i = 0; i < 500; i++) begin
			rreg(lcdxf_pkg::ADDR_XFER, rv);
			if ((rv & m) === v) return;
		end
		hang("transfer status");
	endtask

	// one whole frame: unit count and its first two units
	task automatic frame(int n, logic [7:0] u0, logic [7:0] u1);
		logic f0;
		wait_scan();
		s0 = units.size();
		f0 = fps;
		wait_scan();
		chkn("frame units", n, n, units.size() - s0);
		chk("frame polarity", {23'h0, ~f0}, {23'h0, fps});
		if (units.size() > s0 + 1) begin
			chk("unit 0", u0, units[s0]);
			chk("unit 1", u1, units[s0 + 1]);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk("mode reg", lcdxf_pkg::ADDR_MODE, 8'h00);
		rchk("xfer reg", lcdxf_pkg::ADDR_XFER, 8'h01);
		rchk("irq reg", lcdxf_pkg::ADDR_IRQ, 8'h00);
		rchk("unmapped", 16'hFF70, 8'h00);
		chk("vector", 24'h000024, vec);
	endtask

	task automatic t_cont();
		wreg(lcdxf_pkg::ADDR_MODE, 8'h81);
		wreg(lcdxf_pkg::ADDR_XFER, 8'h0D);
		frame(32, 8'hA5, 8'hA4);
		wreg(lcdxf_pkg::ADDR_XFER, 8'h0F);
		frame(32, 8'hA5, 8'hA4);
		wreg(lcdxf_pkg::ADDR_MODE, 8'h80);
		frame(64, 8'h0A, 8'h05);
		wreg(lcdxf_pkg::ADDR_MODE, 8'hC0);
		frame(64, 8'h05, 8'h0A);
		wreg(lcdxf_pkg::ADDR_MODE, 8'h40);
		frame(64, 8'h00, 8'h00);
		rchk("no flag", lcdxf_pkg::ADDR_IRQ, 8'h00);
	endtask

	task automatic t_div();
		int sels[3] = '{0, 1, 15};
		foreach (sels[i]) begin
			wreg(lcdxf_pkg::ADDR_MODE, 8'h80 | 8'(sels[i] << 2));
			repeat (300) @(posedge clk);
			s0 = nlat;
			repeat (1152) @(posedge clk);
			chkn("lines", 96 / (sels[i] + 2) - 1, 96 / (sels[i] + 2) + 1, nlat - s0);
		end
		wreg(lcdxf_pkg::ADDR_MODE, 8'h80);
	endtask

	task automatic t_oneshot();
		wreg(lcdxf_pkg::ADDR_XFER, 8'h08);
		wait_scan();
		s0 = units.size();
		nlat = 0;
		wait_scan();
		wait_scan();
		chkn("idle units", 0, 0, units.size() - s0);
		chkn("idle latches", 16, 16, nlat);
		wreg(lcdxf_pkg::ADDR_XFER, 8'h0A);
		rchk("busy", lcdxf_pkg::ADDR_XFER, 8'h0A);
		wreg(lcdxf_pkg::ADDR_XFER, 8'h0A);
		poll(8'h02, 8'h00);
		rchk("flag", lcdxf_pkg::ADDR_IRQ, 8'h01);
		chk("masked req", 24'h0, 24'(req));
		wait_scan();
		wait_scan();
		chkn("shot units", 64, 64, units.size() - s0);
		for (int p = 0; p < 4; p++) begin
			wreg(lcdxf_pkg::ADDR_IRQ, 8'(p << 2) | 8'h02);
			rchk("irq reg", lcdxf_pkg::ADDR_IRQ, 8'(p << 2) | 8'h03);
			chk("priority", 24'(p), 24'(prio));
			chk("req", 24'h1, 24'(req));
		end
		wreg(lcdxf_pkg::ADDR_IRQ, 8'h01);
		rchk("cleared", lcdxf_pkg::ADDR_IRQ, 8'h00);
		chk("req off", 24'h0, 24'(req));
	endtask

	task automatic t_auto();
		wreg(lcdxf_pkg::ADDR_XFER, 8'h0C);
		s0 = units.size();
		@(posedge clk);
		dwr <= 1'b1;
		@(posedge clk);
		dwr <= 1'b0;
		poll(8'h10, 8'h10);
		poll(8'h10, 8'h00);
		chkn("auto units", 64, 64, units.size() - s0);
		rchk("auto flag", lcdxf_pkg::ADDR_IRQ, 8'h01);
		wreg(lcdxf_pkg::ADDR_IRQ, 8'h01);
	endtask

	// clock enable low holds all state; then back to continuous refresh
	task automatic t_freeze();
		logic f0;
		wait_scan();
		repeat (4) @(posedge clk);
		s0 = nlat;
		f0 = fps;
		ce <= 1'b0;
		repeat (200) @(posedge clk);
		chkn("frozen latches", 0, 0, nlat - s0);
		chk("frozen polarity", {23'h0, f0}, {23'h0, fps});
		ce <= 1'b1;
		wait_scan();
		rchk("kept xfer", lcdxf_pkg::ADDR_XFER, 8'h0C);
		wreg(lcdxf_pkg::ADDR_XFER, 8'h09);
		frame(64, 8'h0A, 8'h05);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		errors = 0;
		num_checks = 0;
		nlat = 0;
		tcnt = 0;
		tick = 1'b0;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		dwr = 1'b0;
		ce = 1'b1;
		addr = 16'h0000;
		wd = 8'h00;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cont();
		t_div();
		t_oneshot();
		t_auto();
		t_freeze();
		end_of_test();
	end
endmodule // tb
